// [logic/dl_dma_cfg.svh]
// constants of the transmit download engine: offsets, fields, resets
// assumes APB byte addresses in the low address bits
`ifndef DL_DMA_CFG_SVH
`define DL_DMA_CFG_SVH
// apb register byte offsets
`define DL_OFF_LIST 8'h00
`define DL_OFF_POLL 8'h04
`define DL_OFF_CFG 8'h08
`define DL_OFF_CMD 8'h0c
`define DL_OFF_FLAGS 8'h10
`define DL_OFF_STATUS 8'h14
// command and flag bit positions
`define DL_CMD_RING_INSERT 0
`define DL_CMD_HOLD 1
`define DL_CMD_RESUME 2
`define DL_FLAG_DONE 0
`define DL_FLAG_UNDERRUN 1
`define DL_CFG_BURST_SEL 0
// descriptor layout in host memory
`define DL_DESC_LINK 32'h0000_0000
`define DL_DESC_HDR 32'h0000_0004
`define DL_DESC_PAIRS 32'h0000_0008
`define DL_PAIR_STRIDE 32'h0000_0008
`define DL_PAIR_LEN 32'h0000_0004
`define DL_LEN_MSB 14
`define DL_LAST_BIT 31
`define DL_HDR_COMPLETE 16
`define DL_HDR_EMPTY 29
`define DL_HDR_IRQ_REQ 31
`define DL_LAST_PAIR_IDX 6'h3e
// reset values
`define DL_RST_WORD 32'h0000_0000
`define DL_RST_POLL 8'h00
`endif

// [logic/dl_dma_pkg.sv]
// types shared by the transmit download engine
// assumes nothing outside itself
package dl_dma_pkg;
  // gray codes along the usual download path
  typedef enum logic [3:0] {
    st_idle = 4'h0,
    st_hdr = 4'h1,
    st_faddr = 4'h3,
    st_flen = 4'h2,
    st_data = 4'h6,
    st_stat = 4'h7,
    st_hdr2 = 4'h5,
    st_next = 4'h4,
    st_poll = 4'hc
  } dl_state_t;
endpackage

// [logic/dl_dma.sv]
// transmit descriptor download engine: walks descriptors in host memory,
// moves fragment bytes into the transmit fifo, writes completion status.
// assumes an apb master, a one-pulse mem_ack memory master port and a
// transmit fifo on the same clock.
// Overview of operation
// - fragments may start at any byte; engine aligns reads and marks bytes.
// - length entry bits 14:0 give the byte count of the fragment.
// - bit 31 of the length entry ends the fragment walk for a packet.
// - no download starts while the list head pointer is zero.
// - no download starts while the hold command is in force.
// - no download starts after a transmit underrun until cleared.
// - start needs fifo free space >= burst, or empty fifo when select clear.
// - after reset the engine is idle and fetches nothing.
// - once open, a nonzero list head write starts the engine.
// - engine reads descriptor fields and moves fragment bytes to the fifo.
// - at packet end write completion status; raise the done flag if the header irq request bit is set.
// - after a packet, copy the next link into list head; zero idles unless the poll interval is nonzero.
// - polling re-reads a zero link and restarts at a nonzero one.
// - poll interval register sets the gap between link reads.
// - polling only with nonzero interval and after a real link fetch.
// - up to 63 address and length pairs per descriptor are handled.
// - header irq request bit is re-read after download to gate the flag.
// - held state entered only by hold, left only by resume.
`timescale 1ns/1ps
`include "dl_dma_cfg.svh"
module dl_dma #(
  parameter int BURST_WORDS = 8,
  parameter int FREE_W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host memory master
  output logic mem_req,
  output logic mem_write,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // transmit fifo write side
  output logic fifo_wvalid,
  output logic [31:0] fifo_wdata,
  output logic [3:0] fifo_wbe,
  input wire logic fifo_full,
  input wire logic fifo_empty,
  input wire logic [FREE_W-1:0] fifo_free,
  // transmitter status
  input wire logic tx_underrun
);

  dl_dma_pkg::dl_state_t state, next_state;
  logic [31:0] list_head, cur, ptr, frag_addr, hdr;
  logic [14:0] frag_cnt;
  logic frag_last, burst_sel, opened, held, underrun_blk, done_flag;
  logic [5:0] pair_idx;
  logic [7:0] poll_val, poll_cnt;
  logic next_req, next_we, next_fv, next_flast, done_set, list_load;
  logic [31:0] next_addr, next_wdata, next_cur, next_ptr, next_faddr;
  logic [31:0] next_hdr, list_val;
  logic [14:0] next_fcnt;
  logic [5:0] next_pidx;
  logic [7:0] next_pcnt;
  logic [3:0] next_fbe;

  // which bytes of an aligned word belong to the fragment
  function automatic logic [3:0] byte_mask(input logic [1:0] off, input logic [2:0] n);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      m[i] = (3'(i) >= {1'b0, off}) && (3'(i) < ({1'b0, off} + n));
    end
    return m;
  endfunction

  // apb decode; accesses complete at the access edge with pready high
  wire setup = psel & ~penable;
  wire wr = psel & penable & pready & pwrite;
  wire sel_list = paddr == `DL_OFF_LIST;
  wire sel_poll = paddr == `DL_OFF_POLL;
  wire sel_cfg = paddr == `DL_OFF_CFG;
  wire sel_cmd = paddr == `DL_OFF_CMD;
  wire sel_flags = paddr == `DL_OFF_FLAGS;
  wire sel_stat = paddr == `DL_OFF_STATUS;
  wire mapped = sel_list | sel_poll | sel_cfg | sel_cmd | sel_flags | sel_stat;
  wire cmd_insert = wr & sel_cmd & pwdata[`DL_CMD_RING_INSERT];
  wire cmd_hold = wr & sel_cmd & pwdata[`DL_CMD_HOLD];
  wire cmd_resume = wr & sel_cmd & pwdata[`DL_CMD_RESUME];
  wire clr_done = wr & sel_flags & pwdata[`DL_FLAG_DONE];
  wire clr_under = wr & sel_flags & pwdata[`DL_FLAG_UNDERRUN];
  // reading the list head cuts a poll wait short
  wire kick = setup & ~pwrite & sel_list;
  wire [31:0] rd_mux = sel_list ? list_head :
    sel_poll ? {24'h0, poll_val} :
    sel_cfg ? {31'h0, burst_sel} :
    sel_flags ? {30'h0, underrun_blk, done_flag} :
    sel_stat ? {26'h0, state, opened, held} : 32'h0;

  // engine decode
  wire ack = mem_req & mem_ack;
  wire [2:0] avail = 3'h4 - {1'b0, frag_addr[1:0]};
  wire [2:0] take = (frag_cnt < {12'h0, avail}) ? frag_cnt[2:0] : avail;
  wire fifo_ok = burst_sel ? (32'(fifo_free) >= 32'(BURST_WORDS)) : fifo_empty;
  wire start_ok = opened & ~held & ~underrun_blk & (list_head != 32'h0)
    & fifo_ok;

  // next-state logic of the download walk
  always_comb
  begin
    next_state = state;
    next_req = mem_req & ~ack;
    next_we = mem_write;
    next_addr = mem_addr;
    next_wdata = mem_wdata;
    next_cur = cur;
    next_ptr = ptr;
    next_faddr = frag_addr;
    next_fcnt = frag_cnt;
    next_flast = frag_last;
    next_pidx = pair_idx;
    next_hdr = hdr;
    next_pcnt = poll_cnt;
    next_fv = 1'b0;
    next_fbe = fifo_wbe;
    done_set = 1'b0;
    list_load = 1'b0;
    list_val = list_head;
    case (state)
      dl_dma_pkg::st_idle:
      begin
        if (start_ok)
        begin
          next_state = dl_dma_pkg::st_hdr;
          next_req = 1'b1;
          next_we = 1'b0;
          next_addr = list_head + `DL_DESC_HDR;
          next_cur = list_head;
          next_pidx = 6'h0;
        end
      end
      dl_dma_pkg::st_hdr:
      begin
        if (ack)
        begin
          next_hdr = mem_rdata;
          next_req = 1'b1;
          next_ptr = cur + `DL_DESC_PAIRS;
          if (mem_rdata[`DL_HDR_EMPTY])
          begin
            next_state = dl_dma_pkg::st_next;
            next_addr = cur + `DL_DESC_LINK;
          end
          else
          begin
            next_state = dl_dma_pkg::st_faddr;
            next_addr = cur + `DL_DESC_PAIRS;
          end
        end
      end
      dl_dma_pkg::st_faddr:
      begin
        if (ack)
        begin
          next_faddr = mem_rdata;
          next_state = dl_dma_pkg::st_flen;
          next_req = 1'b1;
          next_addr = ptr + `DL_PAIR_LEN;
        end
      end
      dl_dma_pkg::st_flen:
      begin
        if (ack)
        begin
          // bits 30:15 carry nothing for the engine
          next_fcnt = mem_rdata[`DL_LEN_MSB:0];
          next_flast = mem_rdata[`DL_LAST_BIT];
          next_state = dl_dma_pkg::st_data;
        end
      end
      dl_dma_pkg::st_data:
      begin
        if (ack)
        begin
          next_fv = 1'b1;
          next_fbe = byte_mask(frag_addr[1:0], take);
          next_faddr = frag_addr + {29'h0, take};
          next_fcnt = frag_cnt - {12'h0, take};
        end
        else if (!mem_req && frag_cnt == 15'h0)
        begin
          next_req = 1'b1;
          if (frag_last || pair_idx == `DL_LAST_PAIR_IDX)
          begin
            next_state = dl_dma_pkg::st_stat;
            next_we = 1'b1;
            next_addr = cur + `DL_DESC_HDR;
            next_wdata = hdr | (32'h1 << `DL_HDR_COMPLETE);
          end
          else
          begin
            next_state = dl_dma_pkg::st_faddr;
            next_pidx = pair_idx + 6'h1;
            next_ptr = ptr + `DL_PAIR_STRIDE;
            next_addr = ptr + `DL_PAIR_STRIDE;
          end
        end
        else if (!mem_req && !fifo_full)
        begin
          // whole aligned dword read; byte enables trim it
          next_req = 1'b1;
          next_addr = {frag_addr[31:2], 2'h0};
        end
      end
      dl_dma_pkg::st_stat:
      begin
        if (ack)
        begin
          next_state = dl_dma_pkg::st_hdr2;
          next_req = 1'b1;
          next_we = 1'b0;
          next_addr = cur + `DL_DESC_HDR;
        end
      end
      dl_dma_pkg::st_hdr2:
      begin
        if (ack)
        begin
          done_set = mem_rdata[`DL_HDR_IRQ_REQ];
          next_state = dl_dma_pkg::st_next;
          next_req = 1'b1;
          next_addr = cur + `DL_DESC_LINK;
        end
      end
      dl_dma_pkg::st_next:
      begin
        if (ack)
        begin
          list_load = 1'b1;
          list_val = mem_rdata;
          next_pcnt = poll_val;
          if (mem_rdata == 32'h0 && poll_val != 8'h0)
            next_state = dl_dma_pkg::st_poll;
          else
            next_state = dl_dma_pkg::st_idle;
        end
      end
      dl_dma_pkg::st_poll:
      begin
        if (poll_val == 8'h0 || list_head != 32'h0)
          next_state = dl_dma_pkg::st_idle;
        else if (poll_cnt == 8'h0 || kick)
        begin
          next_state = dl_dma_pkg::st_next;
          next_req = 1'b1;
          next_addr = cur + `DL_DESC_LINK;
        end
        else
          next_pcnt = poll_cnt - 8'h1;
      end
      default:
        next_state = dl_dma_pkg::st_idle;
    endcase
  end

  // engine registers; reset leaves it idle with no request out
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= dl_dma_pkg::st_idle;
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_addr <= `DL_RST_WORD;
      mem_wdata <= `DL_RST_WORD;
      cur <= `DL_RST_WORD;
      ptr <= `DL_RST_WORD;
      frag_addr <= `DL_RST_WORD;
      hdr <= `DL_RST_WORD;
      frag_cnt <= 15'h0;
      frag_last <= 1'b0;
      pair_idx <= 6'h0;
      poll_cnt <= `DL_RST_POLL;
      fifo_wvalid <= 1'b0;
      fifo_wdata <= `DL_RST_WORD;
      fifo_wbe <= 4'h0;
    end
    else
    begin
      state <= next_state;
      mem_req <= next_req;
      mem_write <= next_we;
      mem_addr <= next_addr;
      mem_wdata <= next_wdata;
      cur <= next_cur;
      ptr <= next_ptr;
      frag_addr <= next_faddr;
      hdr <= next_hdr;
      frag_cnt <= next_fcnt;
      frag_last <= next_flast;
      pair_idx <= next_pidx;
      poll_cnt <= next_pcnt;
      fifo_wvalid <= next_fv;
      fifo_wdata <= (next_fv) ? mem_rdata : fifo_wdata;
      fifo_wbe <= next_fbe;
    end
  end

  // software registers; engine link copy beats a same-cycle bus write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      list_head <= `DL_RST_WORD;
      poll_val <= `DL_RST_POLL;
      burst_sel <= 1'b0;
      opened <= 1'b0;
      held <= 1'b0;
      underrun_blk <= 1'b0;
      done_flag <= 1'b0;
    end
    else
    begin
      if (list_load)
        list_head <= list_val;
      else if (wr && sel_list)
        list_head <= pwdata;
      if (wr && sel_poll)
        poll_val <= pwdata[7:0];
      if (wr && sel_cfg)
        burst_sel <= pwdata[`DL_CFG_BURST_SEL];
      opened <= opened | cmd_insert;
      held <= cmd_hold | (held & ~cmd_resume);
      // set beats clear so no event is lost
      underrun_blk <= tx_underrun | (underrun_blk & ~clr_under);
      done_flag <= done_set | (done_flag & ~clr_done);
    end
  end

  // apb answer: one wait-free access phase, data caught at setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= `DL_RST_WORD;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata <= setup ? rd_mux : prdata;
      pready <= setup;
      pslverr <= setup & ~mapped;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_start;
    state == dl_dma_pkg::st_idle ##1 state == dl_dma_pkg::st_hdr;
  endsequence

  a_no_start_empty: assert property (
    state == dl_dma_pkg::st_idle && list_head == 32'h0 |=> state == dl_dma_pkg::st_idle)
    else $error("download began with zero list head");
  a_no_start_held: assert property (
    state == dl_dma_pkg::st_idle && held |=> state == dl_dma_pkg::st_idle)
    else $error("download began while held");
  a_no_start_underrun: assert property (
    state == dl_dma_pkg::st_idle && underrun_blk |=> state == dl_dma_pkg::st_idle)
    else $error("download began after underrun");
  a_fifo_start_gate: assert property (
    s_start |-> $past(fifo_ok))
    else $error("download began without fifo room");
  a_hdr_fetch_addr: assert property (
    s_start |-> mem_req && !mem_write && mem_addr == cur + `DL_DESC_HDR)
    else $error("header fetch at wrong address");
  a_length_field: assert property (
    state == dl_dma_pkg::st_flen && ack |=> frag_cnt == $past(mem_rdata[14:0]))
    else $error("fragment count not taken from bits 14:0");
  a_status_write: assert property (
    state == dl_dma_pkg::st_stat && mem_req |-> mem_write && mem_wdata[`DL_HDR_COMPLETE])
    else $error("completion status not written");
  a_irq_gate: assert property (
    state == dl_dma_pkg::st_hdr2 && ack && !mem_rdata[31] && !done_flag |=> !done_flag)
    else $error("done flag raised without request bit");
  a_link_copy: assert property (
    state == dl_dma_pkg::st_next && ack |=> list_head == $past(mem_rdata))
    else $error("next link not copied to list head");
  a_byte_enables: assert property (
    fifo_wvalid |-> fifo_wbe != 4'h0 ##1 !fifo_wvalid)
    else $error("fifo write without bytes or back to back");
  a_pair_limit: assert property (
    pair_idx <= `DL_LAST_PAIR_IDX)
    else $error("pair index past limit");

endmodule

// [dv/host_mem_model.sv]
// host memory model answering the engine's memory master port
// assumes one request at a time, held until its one-cycle acknowledge
`timescale 1ns/1ps
module host_mem_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // memory slave side
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [logic [29:0]];
  int wait_n;

  // word access; unwritten words read back as a scrambled address
  function automatic logic [31:0] get(input logic [31:0] a);
    return mem.exists(a[31:2]) ? mem[a[31:2]] : ~a;
  endfunction
  task automatic put(input logic [31:0] a, input logic [31:0] d);
    mem[a[31:2]] = d;
  endtask
  task automatic put_byte(input logic [31:0] a, input logic [7:0] v);
    logic [31:0] w;
    w = get(a);
    w[8 * a[1:0] +: 8] = v;
    put(a, w);
  endtask

  // random latency of one to four cycles; data toggles outside an acknowledge
  // so a stale capture by the engine cannot pass for good data
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      wait_n = 1;
    end
    else if (mem_ack || !mem_req)
    begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
    else if (wait_n > 0)
    begin
      wait_n = wait_n - 1;
      mem_rdata <= ~mem_rdata;
    end
    else
    begin
      mem_ack <= 1'b1;
      if (mem_write)
        put(mem_addr, mem_wdata);
      mem_rdata <= mem_write ? ~mem_rdata : get(mem_addr);
      wait_n = $urandom_range(3, 0);
    end
endmodule

// [dv/transmit_descriptor_download_dma_test.sv]
// self-checking bench for the download engine: apb master, fifo sink
// assumes host_mem_model and the design files are compiled first
`timescale 1ns/1ps
`include "dl_dma_cfg.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module transmit_descriptor_download_dma_test;
  localparam int BURST = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, mem_addr, mem_wdata, mem_rdata, fifo_wdata;
  logic pready, pslverr, mem_req, mem_write, mem_ack, fifo_wvalid;
  logic [3:0] fifo_wbe;
  logic fifo_full = 1'b0, fifo_empty = 1'b1, tx_underrun = 1'b0;
  logic [7:0] fifo_free = 8'hff;
  logic seen_req = 1'b0;
  logic [31:0] poll_addr = 32'h0000_0000;
  logic [7:0] got[$], exp_q[$];
  int n_fail = 0, checks = 0, cyc = 0, link_reads = 0, gap_bad = 0, last_rd = -1000;
  int poll_val = 0;

  dl_dma #(.BURST_WORDS(BURST), .FREE_W(8)) i_dl_dma (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .fifo_wvalid(fifo_wvalid), .fifo_wdata(fifo_wdata),
    .fifo_wbe(fifo_wbe), .fifo_full(fifo_full), .fifo_empty(fifo_empty),
    .fifo_free(fifo_free), .tx_underrun(tx_underrun));
  host_mem_model i_host_mem_model (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  always #2.5 pclk = ~pclk;

  // fifo sink keeping enabled bytes; random back-pressure; link read spacing
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    fifo_full <= ($urandom_range(3, 0) == 0);
    if (mem_req)
      seen_req <= 1'b1;
    if (fifo_wvalid)
      for (int b = 0; b < 4; b++)
        if (fifo_wbe[b])
          got.push_back(fifo_wdata[8 * b +: 8]);
    if (mem_req && mem_ack && !mem_write && mem_addr == poll_addr)
    begin
      link_reads++;
      if (cyc - last_rd < poll_val)
        gap_bad++;
      last_rd = cyc;
    end
  end

  task automatic results();
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one apb transfer; pready sampled at the rising edge, request held until then
  // leading edge wait keeps a release and the next setup out of one time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
  endtask

  function automatic logic [31:0] dbase(input int k);
    return 32'h0001_0000 + 32'(k) * 32'h1000;
  endfunction

  // descriptor with random byte-aligned fragments; junk in length bits 30:15
  task automatic build(input int k, input int nf, input logic [31:0] hdr,
                       input logic [31:0] link);
    logic [31:0] b, fa;
    int len;
    logic [7:0] v;
    b = dbase(k);
    i_host_mem_model.put(b, link);
    i_host_mem_model.put(b + 4, hdr);
    for (int i = 0; i < nf; i++)
    begin
      fa = b + 32'h400 + 32'(i) * 32'h20 + 32'($urandom_range(7, 0));
      len = (nf > 8) ? $urandom_range(2, 1) : $urandom_range(24, 0);
      i_host_mem_model.put(b + 8 + 8 * i, fa);
      i_host_mem_model.put(b + 12 + 8 * i, {i == nf - 1, 16'($urandom), 15'(len)});
      for (int j = 0; j < len; j++)
      begin
        v = 8'($urandom);
        i_host_mem_model.put_byte(fa + 32'(j), v);
        exp_q.push_back(v);
      end
    end
  endtask

  task automatic quiet(input int n);
    seen_req = 1'b0;
    repeat (n) @(posedge pclk);
    `CHK(seen_req, 1'b0)
  endtask

  task automatic wait_idle();
    logic [31:0] s;
    int n;
    n = 0;
    repeat (4) @(posedge pclk);
    do
    begin
      rd(`DL_OFF_STATUS, s);
      n++;
    end
    while (s[5:2] !== dl_dma_pkg::st_idle && n < 3000);
    if (n >= 3000)
      n_fail++;
  endtask

  // fifo bytes, completion status, list head copy, done flag
  task automatic done_chk(input int k, input logic [31:0] hdr, input logic [31:0] link);
    logic [31:0] r;
    `CHK(got.size(), exp_q.size())
    foreach (exp_q[i])
      if (i < got.size())
        `CHK(got[i], exp_q[i])
    `CHK(i_host_mem_model.get(dbase(k) + 4), hdr | 32'h0001_0000)
    rd(`DL_OFF_LIST, r);
    `CHK(r, link)
    rd(`DL_OFF_FLAGS, r);
    `CHK(r[0], hdr[31])
    wr(`DL_OFF_FLAGS, 32'h0000_0003);
    got.delete();
    exp_q.delete();
  endtask

  initial
  begin
    logic [31:0] r, h;
    logic e;
    int nf;
    r = $urandom(53);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`DL_OFF_STATUS, r);
    `CHK(r, 32'h0000_0000)
    apb(1'b0, 8'h20, 32'h0000_0000, r, e);
    `CHK(e, 1'b1)
    `CHK(r, 32'h0000_0000)
    quiet(20);
    wr(`DL_OFF_CMD, 32'h0000_0001);
    wr(`DL_OFF_LIST, 32'h0000_0000);
    quiet(30);
    build(1, 3, 32'h8000_0000, 32'h0);
    wr(`DL_OFF_CMD, 32'h0000_0002);
    wr(`DL_OFF_LIST, dbase(1));
    quiet(30);
    rd(`DL_OFF_STATUS, r);
    `CHK(r[0], 1'b1)
    wr(`DL_OFF_CMD, 32'h0000_0004);
    wait_idle();
    done_chk(1, 32'h8000_0000, 32'h0);
    tx_underrun <= 1'b1;
    @(posedge pclk);
    tx_underrun <= 1'b0;
    build(2, 2, 32'h0, 32'h0);
    wr(`DL_OFF_LIST, dbase(2));
    quiet(30);
    wr(`DL_OFF_FLAGS, 32'h0000_0002);
    wait_idle();
    done_chk(2, 32'h0, 32'h0);
    wr(`DL_OFF_CFG, 32'h0000_0001);
    fifo_free <= 8'(BURST - 1);
    build(3, 1, 32'h8000_0000, 32'h0);
    wr(`DL_OFF_LIST, dbase(3));
    quiet(30);
    fifo_free <= 8'(BURST);
    wait_idle();
    done_chk(3, 32'h8000_0000, 32'h0);
    wr(`DL_OFF_CFG, 32'h0000_0000);
    fifo_empty <= 1'b0;
    build(4, 1, 32'h0, 32'h0);
    wr(`DL_OFF_LIST, dbase(4));
    quiet(30);
    fifo_empty <= 1'b1;
    wait_idle();
    done_chk(4, 32'h0, 32'h0);
    for (int t = 5; t < 11; t++)
    begin
      h = {1'($urandom), 31'h0};
      nf = (t == 5) ? 63 : $urandom_range(4, 1);
      build(t, nf, h, 32'h0);
      wr(`DL_OFF_LIST, dbase(t));
      wait_idle();
      done_chk(t, h, 32'h0);
    end
    build(12, 2, 32'h0, dbase(13));
    build(13, 1, 32'h8000_0000, 32'h0);
    wr(`DL_OFF_LIST, dbase(12));
    wait_idle();
    `CHK(i_host_mem_model.get(dbase(12) + 4), 32'h0001_0000)
    done_chk(13, 32'h8000_0000, 32'h0);
    poll_val = 6;
    poll_addr = dbase(20);
    wr(`DL_OFF_POLL, 32'h0000_0006);
    build(20, 0, 32'h2000_0000, 32'h0);
    wr(`DL_OFF_LIST, dbase(20));
    repeat (100) @(posedge pclk);
    `CHK(link_reads > 4, 1'b1)
    `CHK(gap_bad, 0)
    build(21, 2, 32'h8000_0000, 32'h0);
    i_host_mem_model.put(dbase(20), dbase(21));
    nf = 0;
    while (got.size() < exp_q.size() && nf < 3000)
    begin
      @(posedge pclk);
      nf++;
    end
    if (nf >= 3000)
      n_fail++;
    repeat (40) @(posedge pclk);
    wr(`DL_OFF_POLL, 32'h0000_0000);
    wait_idle();
    done_chk(21, 32'h8000_0000, 32'h0);
    results();
  end

  // hang guard, well past the expected length of the run
  initial
  begin
    repeat (100000) @(posedge pclk);
    n_fail++;
    results();
  end
endmodule
